/* design/gpfs_top.sv */
// General pin function select: AHB-Lite registers, pin routing, lane mode
`timescale 1ns/1ps
module gpfs_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wafer_package_pin,
  input wire logic [3:0] pin_claimed,
  input wire logic busy_indicator,
  input wire logic threshold_alert_state,
  input wire logic overvoltage_state,
  input wire logic [3:0] gpo_level,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic overvoltage_alert_status_flag,
  output gpfs_pkg::gpfs_lanes_t serial_output_lane_mode
);
  logic [7:0] pin_function_control;
  logic [7:0] general_pin_direction_enables;
  logic wafer_meta;
  logic wafer;
  logic wr_pend;
  logic [7:0] wr_idx;
  gpfs_pkg::gpfs_pins_t pins_q;
  gpfs_pkg::gpfs_src_t src;
  gpfs_pkg::gpfs_pins_t next_pins;
  gpfs_pkg::gpfs_lanes_t next_lanes;

  // Zero-wait slave, every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase decode; hsize is not checked, only words are issued
  wire logic req = hsel & htrans[1] & hready;
  wire logic rd_req = req & ~hwrite;
  wire logic wr_req = req & hwrite;
  wire logic [7:0] req_idx = haddr[9:2];
  wire logic addr_ok = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
  wire logic unused_size = ^hsize;

  // Data phase write strobes
  wire logic wr_func = wr_pend & (wr_idx == gpfs_pkg::REG_IDX_FUNC);
  wire logic wr_dir = wr_pend & (wr_idx == gpfs_pkg::REG_IDX_DIR);

  // Next register values; reserved bit six is never stored
  wire logic [7:0] next_func = wr_func ? (hwdata[7:0] & gpfs_pkg::FUNC_WMASK)
                                       : pin_function_control;
  wire logic [7:0] next_dir = wr_dir ? hwdata[7:0] : general_pin_direction_enables;

  // Status view of the block's own output state and the synchronised package strap
  wire logic [7:0] stat_word = {wafer,
                                serial_output_lane_mode == gpfs_pkg::LANE_QUAD,
                                serial_output_lane_mode == gpfs_pkg::LANE_DUAL,
                                overvoltage_alert_status_flag,
                                pins_q.drive};

  // Read mux forwards a write still in its data phase so back-to-back reads see it
  wire logic [7:0] rd_byte =
    ~addr_ok ? 8'h00 :
    (req_idx == gpfs_pkg::REG_IDX_FUNC) ? next_func :
    (req_idx == gpfs_pkg::REG_IDX_DIR) ? next_dir :
    (req_idx == gpfs_pkg::REG_IDX_STAT) ? stat_word : 8'h00;

  // Bus capture and register storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h0000_0000;
      pin_function_control <= gpfs_pkg::FUNC_RESET;
      general_pin_direction_enables <= gpfs_pkg::DIR_RESET;
    end else begin
      wr_pend <= wr_req & addr_ok;
      wr_idx <= req_idx;
      hrdata <= rd_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pin_function_control <= next_func;
      general_pin_direction_enables <= next_dir;
    end
  end

  // Package strap comes from a pin, so it is synchronised first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wafer_meta <= 1'b0;
      wafer <= 1'b0;
    end else begin
      wafer_meta <= wafer_package_pin;
      wafer <= wafer_meta;
    end
  end

  // Sources for the pin router
  assign src.busy = busy_indicator;
  assign src.alert = threshold_alert_state;
  assign src.claimed = pin_claimed;
  assign src.gpo = gpo_level;

  gpfs_pin_route #(.PINS(gpfs_pkg::PINS)) u_route (
    .func(pin_function_control),
    .dir(general_pin_direction_enables),
    .wafer(wafer),
    .src(src),
    .pins(next_pins)
  );

  // Lane decode; code 10 falls back to one lane on lead-frame parts
  wire logic [1:0] lane_code = pin_function_control[gpfs_pkg::FUNC_LANE_LO +: 2];
  always_comb begin
    unique case (lane_code)
      gpfs_pkg::LANE_CODE_DUAL: next_lanes = gpfs_pkg::LANE_DUAL;
      gpfs_pkg::LANE_CODE_QUAD: next_lanes = wafer ? gpfs_pkg::LANE_QUAD
                                                   : gpfs_pkg::LANE_SINGLE;
      default: next_lanes = gpfs_pkg::LANE_SINGLE;
    endcase
  end

  // Flag shows the threshold alert only when mapping is selected
  wire logic next_ov = pin_function_control[gpfs_pkg::FUNC_MAP] ? threshold_alert_state
                                                                : overvoltage_state;

  // Output flops; one cycle from the source inputs to the pins, three from the package strap pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_q <= '0;
      overvoltage_alert_status_flag <= 1'b0;
      serial_output_lane_mode <= gpfs_pkg::LANE_SINGLE;
    end else begin
      pins_q <= next_pins;
      overvoltage_alert_status_flag <= next_ov;
      serial_output_lane_mode <= next_lanes;
    end
  end

  assign pin_out = pins_q.level;
  assign pin_oe = pins_q.drive;

  // Checks on the block's own registers and outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic past_ok;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      past_ok <= 1'b0;
    end else begin
      past_ok <= 1'b1;
    end
  end

  wire logic [7:0] f = pin_function_control;
  wire logic [7:0] d = general_pin_direction_enables;

  a_reserved_bit_zero: assert property (f[gpfs_pkg::FUNC_RSVD] == 1'b0)
    else $error("reserved bit six stored a one");

  a_func_write_lands: assert property (wr_func |=> f == $past(hwdata[7:0] & 8'hBF))
    else $error("control write did not land");

  a_ov_maps_alert: assert property (past_ok && $past(f[7])
    |-> overvoltage_alert_status_flag == $past(threshold_alert_state))
    else $error("flag does not follow threshold alert");

  a_ov_hides_alert: assert property (past_ok && !$past(f[7])
    |-> overvoltage_alert_status_flag == $past(overvoltage_state))
    else $error("flag reports alert while mapping is off");

  a_busy_pin_zero: assert property (
    past_ok && $past(f[1] && !f[5] && !pin_claimed[0])
    |-> pin_oe[0] && pin_out[0] == $past(busy_indicator))
    else $error("busy missing on pin zero");

  a_busy_pin_three: assert property (
    past_ok && $past(f[1] && f[5] && wafer && !pin_claimed[3])
    |-> pin_oe[3] && pin_out[3] == $past(busy_indicator))
    else $error("busy missing on pin three");

  a_alert_pin_two: assert property (
    past_ok && $past(f[0] && f[4] && wafer && !pin_claimed[2])
    |-> pin_oe[2] && pin_out[2] == $past(threshold_alert_state))
    else $error("alert missing on pin two");

  // Alert lands on pin zero when its select is off or forced back by the package
  a_alert_pin_zero: assert property (
    past_ok && $past(f[0] && !f[1] && !(f[4] && wafer) && !pin_claimed[0])
    |-> pin_oe[0] && pin_out[0] == $past(threshold_alert_state))
    else $error("alert missing on pin zero");

  a_lead_frame_quiet: assert property (past_ok && $past(!wafer)
    |-> pin_oe[3:1] == 3'h0)
    else $error("lead-frame pin one to three driven");

  a_gpo_pin_two: assert property (
    past_ok && $past(wafer && d[2] && !pin_claimed[2] && !(f[0] && f[4]))
    |-> pin_oe[2] && pin_out[2] == $past(gpo_level[2]))
    else $error("pin two general output wrong");

  a_gpo_pin_one: assert property (
    past_ok && $past(wafer && d[1] && !pin_claimed[1])
    |-> pin_oe[1] && pin_out[1] == $past(gpo_level[1]))
    else $error("pin one general output wrong");

  a_gpo_pin_zero: assert property (
    past_ok && $past(d[0] && !pin_claimed[0] && f[1:0] == 2'h0)
    |-> pin_oe[0] && pin_out[0] == $past(gpo_level[0]))
    else $error("pin zero general output wrong");

  a_claimed_released: assert property (past_ok && $past(pin_claimed[0])
    |-> !pin_oe[0])
    else $error("claimed pin still driven");

  a_lane_quad_gate: assert property (past_ok && $past(f[3:2] == 2'h2)
    |-> serial_output_lane_mode == ($past(wafer) ? gpfs_pkg::LANE_QUAD
                                                 : gpfs_pkg::LANE_SINGLE))
    else $error("code 10 lane mode wrong");

  a_lane_dual_code: assert property (past_ok && $past(f[3:2] == 2'h1)
    |-> serial_output_lane_mode == gpfs_pkg::LANE_DUAL)
    else $error("code 01 lane mode wrong");

  c_busy_pin_three: cover property (pin_oe[3] && f[1] && f[5]);
  c_alert_pin_two: cover property (pin_oe[2] && f[0] && f[4]);
  c_quad_lanes: cover property (serial_output_lane_mode == gpfs_pkg::LANE_QUAD);
  c_func_write: cover property (wr_func ##1 rd_req);
endmodule // gpfs_top

/* design/gpfs_pkg.sv */
// Package of constants and carrier types for the general pin function select block
package gpfs_pkg;
  localparam int PINS = 4;
  // Register indices; byte address is four times the index
  localparam logic [7:0] REG_IDX_DIR = 8'h26;
  localparam logic [7:0] REG_IDX_FUNC = 8'h27;
  localparam logic [7:0] REG_IDX_STAT = 8'h2A;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam logic [7:0] FUNC_WMASK = 8'hBF;
  // Function control field positions
  localparam int FUNC_ALERT_EN = 0;
  localparam int FUNC_BUSY_EN = 1;
  localparam int FUNC_LANE_LO = 2;
  localparam int FUNC_ALERT_SEL = 4;
  localparam int FUNC_BUSY_SEL = 5;
  localparam int FUNC_RSVD = 6;
  localparam int FUNC_MAP = 7;
  // Lane mode codes
  localparam logic [1:0] LANE_CODE_DUAL = 2'h1;
  localparam logic [1:0] LANE_CODE_QUAD = 2'h2;
  // Status register field positions
  localparam int STAT_OV = 4;
  localparam int STAT_DUAL = 5;
  localparam int STAT_QUAD = 6;
  localparam int STAT_WAFER = 7;
  // Fixed pin numbers for the movable indicators
  localparam int PIN_ZERO = 0;
  localparam int PIN_ALERT_ALT = 2;
  localparam int PIN_BUSY_ALT = 3;

  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} gpfs_lanes_t;

  // What a pin is doing and at which level
  typedef struct packed {
    logic [PINS-1:0] drive;
    logic [PINS-1:0] level;
  } gpfs_pins_t;

  // Sources that may appear on a pin
  typedef struct packed {
    logic busy;
    logic alert;
    logic [PINS-1:0] claimed;
    logic [PINS-1:0] gpo;
  } gpfs_src_t;
endpackage

/* design/gpfs_pin_route.sv */
// Per-pin function arbitration for the general pins
`timescale 1ns/1ps
module gpfs_pin_route #(
  parameter int PINS = gpfs_pkg::PINS
) (
  input wire logic [7:0] func,
  input wire logic [7:0] dir,
  input wire logic wafer,
  input wire gpfs_pkg::gpfs_src_t src,
  output gpfs_pkg::gpfs_pins_t pins
);
  // Selects collapse to pin zero on the lead-frame package
  wire logic busy_alt = wafer & func[gpfs_pkg::FUNC_BUSY_SEL];
  wire logic alert_alt = wafer & func[gpfs_pkg::FUNC_ALERT_SEL];
  wire logic busy_on = func[gpfs_pkg::FUNC_BUSY_EN];
  wire logic alert_on = func[gpfs_pkg::FUNC_ALERT_EN];

  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_pin
      wire logic busy_here;
      wire logic alert_here;
      wire logic gpo_here;
      wire logic gpo_ok;
      // Pins other than zero exist only on the wafer-level package
      assign gpo_ok = (p == gpfs_pkg::PIN_ZERO) | wafer;
      assign busy_here = busy_on & (busy_alt ? (p == gpfs_pkg::PIN_BUSY_ALT)
                                             : (p == gpfs_pkg::PIN_ZERO));
      assign alert_here = alert_on & (alert_alt ? (p == gpfs_pkg::PIN_ALERT_ALT)
                                                : (p == gpfs_pkg::PIN_ZERO));
      assign gpo_here = dir[p] & gpo_ok;
      // A claimed pin belongs to a higher function, so we let go of it
      assign pins.drive[p] = ~src.claimed[p] & (busy_here | alert_here | gpo_here);
      // Busy beats alert beats general output when they share a pin
      assign pins.level[p] = busy_here ? src.busy :
                             alert_here ? src.alert : src.gpo[p];
    end
  endgenerate
endmodule // gpfs_pin_route

/* dv/tb_general_pin_function_select.sv */
// Self-checking bench for the general pin function select block
`timescale 1ns/1ps
module tb_general_pin_function_select;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, flag;
  logic [31:0] hrdata, rd;
  logic wafer = 1'b1, busy = 1'b0, thr = 1'b0, ov = 1'b0;
  logic [3:0] claimed = 4'h0, gpo = 4'h0, pin_out, pin_oe;
  gpfs_pkg::gpfs_lanes_t lane;
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [7:0] DIR = gpfs_pkg::REG_IDX_DIR;
  localparam logic [7:0] FUNC = gpfs_pkg::REG_IDX_FUNC;

  // Bus ready is looped back, so the slave alone decides the wait
  gpfs_top DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wafer_package_pin(wafer),
    .pin_claimed(claimed), .busy_indicator(busy), .threshold_alert_state(thr),
    .overvoltage_state(ov), .gpo_level(gpo), .pin_out(pin_out), .pin_oe(pin_oe),
    .overvoltage_alert_status_flag(flag), .serial_output_lane_mode(lane));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for ready at a rising edge; only the watchdog ends a stuck wait
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1);
    // Zero-wait slave answers at the first edge of every phase
    chk("ready wait", 32'h1, n);
  endtask

  // One single word transfer; read data is taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Inputs of the converter side change together at one edge
  task automatic drive_in(input logic w, b, t, o, input logic [3:0] c, g);
    @(posedge clk);
    wafer <= w;
    busy <= b;
    thr <= t;
    ov <= o;
    claimed <= c;
    gpo <= g;
  endtask

  // Strap needs two edges, outputs one more; five leaves margin
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic pins(input string what, input logic [3:0] oe, input logic [3:0] lvl);
    settle();
    chk({what, " oe"}, {28'h0, oe}, {28'h0, pin_oe});
    chk({what, " level"}, {28'h0, lvl}, {28'h0, pin_out & pin_oe});
  endtask

  task automatic t_reset();
    #1;
    chk("oe after reset", 32'h0, {28'h0, pin_oe});
    chk("lane after reset", 32'h0, 32'(lane));
    bus(1'b0, FUNC, 8'h00);
    chk("func reset", 32'h0, rd);
    bus(1'b0, DIR, 8'h00);
    chk("dir reset", 32'h0, rd);
  endtask

  task automatic t_regs();
    bus(1'b1, FUNC, 8'hFF);
    bus(1'b0, FUNC, 8'h00);
    chk("func readback", 32'hBF, rd);
    bus(1'b1, DIR, 8'hA5);
    bus(1'b0, DIR, 8'h00);
    chk("dir readback", 32'hA5, rd);
    bus(1'b1, 8'h40, 8'hFF);
    bus(1'b0, 8'h40, 8'h00);
    chk("unmapped read", 32'h0, rd);
    bus(1'b1, FUNC, 8'h00);
  endtask

  task automatic t_lane();
    gpfs_pkg::gpfs_lanes_t exp;
    for (int w = 0; w < 2; w++) begin
      drive_in(w[0], 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
      for (int c = 0; c < 4; c++) begin
        bus(1'b1, FUNC, {4'h0, c[1:0], 2'h0});
        exp = (c == 1) ? gpfs_pkg::LANE_DUAL : gpfs_pkg::LANE_SINGLE;
        if (c == 2 && w == 1) exp = gpfs_pkg::LANE_QUAD;
        settle();
        chk("lane mode", 32'(exp), 32'(lane));
      end
    end
  endtask

  task automatic t_flag();
    bus(1'b1, FUNC, 8'h80);
    drive_in(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0);
    settle();
    chk("flag mapped alert", 32'h1, {31'h0, flag});
    drive_in(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0);
    settle();
    chk("flag mapped quiet", 32'h0, {31'h0, flag});
    bus(1'b1, FUNC, 8'h00);
    drive_in(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0);
    settle();
    chk("flag unmapped", 32'h0, {31'h0, flag});
  endtask

  task automatic t_gpo();
    bus(1'b1, DIR, 8'h0F);
    drive_in(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'hA);
    pins("gpo wafer", 4'hF, 4'hA);
    drive_in(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'hB);
    pins("gpo leadframe", 4'h1, 4'h1);
    drive_in(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'hF);
    pins("gpo claimed", 4'hE, 4'hE);
    bus(1'b1, DIR, 8'h00);
  endtask

  task automatic t_ind();
    bus(1'b1, FUNC, 8'h02);
    drive_in(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    pins("busy pin zero", 4'h1, 4'h1);
    bus(1'b1, DIR, 8'h01);
    drive_in(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'hF);
    pins("busy over gpo", 4'h1, 4'h0);
    bus(1'b1, FUNC, 8'h22);
    drive_in(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    pins("busy pin three", 4'h9, 4'h8);
    drive_in(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    pins("busy sel ignored", 4'h1, 4'h1);
    bus(1'b1, DIR, 8'h00);
    bus(1'b1, FUNC, 8'h11);
    drive_in(1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 4'h0);
    pins("alert pin two", 4'h4, 4'h4);
    drive_in(1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 4'h0);
    pins("alert sel ignored", 4'h1, 4'h1);
    bus(1'b1, FUNC, 8'h03);
    drive_in(1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 4'h0);
    pins("busy over alert", 4'h1, 4'h0);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_lane();
    t_flag();
    t_gpo();
    t_ind();
    give_verdict();
  end
endmodule // tb_general_pin_function_select
